// ### hdl/sfr_pkg.sv
// package: constants and types of the serial flash read/reset logic
// Functional notes
// - dual I/O read takes address two bits/clock
// - mode byte follows address; bits 5:4 decide
// - host releases lines before first data fall
// - quad I/O read uses four lines, dummy clocks
// - quad read, wrap setup need quad enable
// - mode bits 10: next read skips opcode
// - other mode bits: next command has opcode
// - reset ignored while opcode skip mode active
// - wrapped quad read loops within aligned section
// - wrap setup: 77h, 24 dummy, wrap byte
// - wrap disable bit 0 enables; 6:5 length
// - wrap disable powers up 1, setting persists
// - four-bit command mode quad read never wraps
// - four-bit mode dummy 4/6/8, default 4
// - four-bit mode counts mode clocks as dummy
// - reset clears parameters, wrap bits, volatile state
// - host repeats operation interrupted by reset
// - reset ignored during deep power-down
// - reset is 66h then 99h, hold, wait
// - other command after 66h disarms reset
// - unwrapped read address increments per byte
package sfr_pkg;
  localparam logic [7:0]  OP_DIO        = 8'hBB;
  localparam logic [7:0]  OP_QIO        = 8'hEB;
  localparam logic [7:0]  OP_WRAP       = 8'h77;
  localparam logic [7:0]  OP_RSTEN      = 8'h66;
  localparam logic [7:0]  OP_RST        = 8'h99;
  localparam logic [1:0]  SKIP_CODE     = 2'h2;
  localparam logic [2:0]  WRAP_PWRUP    = 3'h1;
  localparam logic [7:0]  PARAM_PWRUP   = 8'h00;
  localparam logic [23:0] WRAP_MIN_LEN  = 24'h000008;
  localparam logic [2:0]  W1            = 3'h1;
  localparam logic [2:0]  W2            = 3'h2;
  localparam logic [2:0]  W4            = 3'h4;
  localparam logic [3:0]  OE_OFF        = 4'hF;
  localparam logic [3:0]  OE_SINGLE     = 4'hE;
  localparam logic [3:0]  OE_DUAL       = 4'hC;
  localparam logic [3:0]  OE_QUAD       = 4'h0;
  localparam logic [5:0]  OPC_SPI_CLKS  = 6'h08;
  localparam logic [5:0]  OPC_QPI_CLKS  = 6'h02;
  localparam logic [5:0]  ADDR_DUAL     = 6'h0C;
  localparam logic [5:0]  ADDR_QUAD     = 6'h06;
  localparam logic [5:0]  MODE_DUAL     = 6'h04;
  localparam logic [5:0]  MODE_QUAD     = 6'h02;
  localparam logic [5:0]  WRAP_SET_CLKS = 6'h08;
  localparam logic [5:0]  DUM_DIO       = 6'h00;
  localparam logic [5:0]  DUM_QIO_SPI   = 6'h04;
  localparam logic [5:0]  DUM_QPI_MIN   = 6'h04;
  localparam logic [5:0]  DUM_QPI_MID   = 6'h06;
  localparam logic [5:0]  DUM_QPI_MAX   = 6'h08;
  localparam logic [2:0]  NIB_LAST_DUAL = 3'h3;
  localparam logic [2:0]  NIB_LAST_QUAD = 3'h1;
  localparam int          SYS_PERIOD_NS = 50;
  localparam int          RCH_NS        = 100;
  localparam int          RST_NS        = 1000;
  localparam logic [11:0] RCH_CYC       =
    12'((RCH_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam logic [11:0] RST_CYC       =
    12'((RST_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS);
  localparam int          SCLK_HALF     = 4;
  localparam logic [11:0] CS_GAP_CYC    = 12'h008;

  typedef enum logic [2:0] {
    D_IDLE = 3'h0, D_OPC = 3'h1, D_ADDR = 3'h2, D_MODE = 3'h3,
    D_DUM  = 3'h4, D_DATA = 3'h5, D_WRAP = 3'h6, D_IGN = 3'h7
  } sfr_dstate_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0, H_SETUP = 3'h1, H_RUN = 3'h2, H_HOLD = 3'h3,
    H_GAP  = 3'h4
  } sfr_hstate_e;

  typedef enum logic [1:0] {
    K_DUAL = 2'h0, K_QUAD = 2'h1, K_WRAP = 2'h2, K_RESET = 2'h3
  } sfr_kind_e;
endpackage : sfr_pkg

// ### hdl/sfr_if.sv
// interface: serial flash link between host controller and device
`timescale 1ns/1ps
`default_nettype none
interface sfr_if;
  logic       sclk;
  logic       cs_n;
  logic [3:0] h_io_o;
  logic [3:0] h_io_oe_n;
  logic [3:0] d_io_o;
  logic [3:0] d_io_oe_n;
  logic [3:0] io;

  // wire level with pull-up where nobody drives
  assign io = (~h_io_oe_n & h_io_o) | (~d_io_oe_n & d_io_o)
            | (h_io_oe_n & d_io_oe_n);

  modport dev  (input sclk, cs_n, io, output d_io_o, d_io_oe_n);
  modport host (output sclk, cs_n, h_io_o, h_io_oe_n, input io);
endinterface : sfr_if
`default_nettype wire

// ### hdl/sfr_dev.sv
// module: flash device end, I/O reads, wrap setup and software reset
`timescale 1ns/1ps
`default_nettype none
module sfr_dev
  import sfr_pkg::*;
(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  sfr_if.dev               LNK,
  input  wire logic        QUAD_ENABLE_BIT,
  input  wire logic        QPI_MODE,
  input  wire logic        POWERDOWN,
  input  wire logic        PARAM_LD,
  input  wire logic [7:0]  PARAM_IN,
  input  wire logic [7:0]  MEM_DATA,
  output logic      [23:0] MEM_ADDR,
  output logic      [2:0]  WRAP_CONFIG_BITS,
  output logic      [7:0]  READ_PARAMETER_BITS,
  output logic             CRM_ACTIVE,
  output logic             RESET_ARMED,
  output logic             SW_RESET
);
  logic [2:0]  sclk_s_ff;
  logic [2:0]  cs_s_ff;
  logic [3:0]  io_s1_ff;
  logic [3:0]  io_s2_ff;
  sfr_dstate_e state_ff;
  logic [5:0]  cnt_ff;
  logic [5:0]  len_ff;
  logic [2:0]  w_ff;
  logic        dual_ff;
  logic [23:0] sh_ff;
  logic [23:0] nxt_sh;
  logic [23:0] addr_ff;
  logic [23:0] nxt_addr;
  logic [23:0] wmask;
  logic [2:0]  nib_ff;
  logic [7:0]  dsh_ff;
  logic [7:0]  cur;
  logic [3:0]  dout_ff;
  logic [3:0]  doe_n_ff;
  logic        crm_ff;
  logic        crm_dual_ff;
  logic [2:0]  wrap_ff;
  logic [7:0]  param_ff;
  logic        armed_ff;
  logic        pend_ff;
  logic [11:0] hold_ff;
  logic        sw_rst_ff;
  logic        sclk_rise;
  logic        sclk_fall;
  logic        cs_lo;
  logic        cs_fall;
  logic        cs_rise;
  logic        shifting;
  logic        ph_end;
  logic        last_nib;
  logic        wrap_on;
  logic [5:0]  qpi_dum;
  logic [5:0]  dum_extra;
  logic [7:0]  op;

  //////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge finders
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      sclk_s_ff <= 3'h0;
      cs_s_ff   <= 3'h7;
      io_s1_ff  <= 4'hF;
      io_s2_ff  <= 4'hF;
    end else begin
      sclk_s_ff <= {sclk_s_ff[1:0], LNK.sclk};
      cs_s_ff   <= {cs_s_ff[1:0], LNK.cs_n};
      io_s1_ff  <= LNK.io;
      io_s2_ff  <= io_s1_ff;
    end
  end

  assign sclk_rise = sclk_s_ff[1] & ~sclk_s_ff[2];
  assign sclk_fall = ~sclk_s_ff[1] & sclk_s_ff[2];
  assign cs_lo     = ~cs_s_ff[1];
  assign cs_fall   = ~cs_s_ff[1] & cs_s_ff[2];
  assign cs_rise   = cs_s_ff[1] & ~cs_s_ff[2];

  //////////////////////////////////////////////////////////////////////
  // input shifter, lane width follows the phase
  always_comb begin
    unique case (w_ff)
      W1:      nxt_sh = {sh_ff[22:0], io_s2_ff[0]};
      W2:      nxt_sh = {sh_ff[21:0], io_s2_ff[1:0]};
      default: nxt_sh = {sh_ff[19:0], io_s2_ff};
    endcase
  end

  assign shifting = (state_ff == D_OPC) || (state_ff == D_ADDR)
                 || (state_ff == D_MODE) || (state_ff == D_DUM)
                 || (state_ff == D_WRAP);
  assign ph_end   = shifting && sclk_rise && (cnt_ff == len_ff - 6'h01);
  assign op       = nxt_sh[7:0];

  always_comb begin
    if (param_ff[5:4] == 2'h3) begin
      qpi_dum = DUM_QPI_MAX;
    end else if (param_ff[5:4] == 2'h2) begin
      qpi_dum = DUM_QPI_MID;
    end else begin
      qpi_dum = DUM_QPI_MIN;
    end
    if (dual_ff) begin
      dum_extra = DUM_DIO;
    end else if (QPI_MODE) begin
      dum_extra = qpi_dum - MODE_QUAD;
    end else begin
      dum_extra = DUM_QIO_SPI;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // command sequencer
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      state_ff <= D_IDLE;
      cnt_ff   <= 6'h00;
      len_ff   <= OPC_SPI_CLKS;
      w_ff     <= W1;
      dual_ff  <= 1'b0;
      sh_ff    <= 24'h000000;
    end else if (!cs_lo) begin
      state_ff <= D_IDLE;
      cnt_ff   <= 6'h00;
    end else begin
      if (shifting && sclk_rise) begin
        sh_ff  <= nxt_sh;
        cnt_ff <= ph_end ? 6'h00 : cnt_ff + 6'h01;
      end
      unique case (state_ff)
        D_IDLE: if (cs_fall) begin
          if (crm_ff) begin
            state_ff <= D_ADDR;
            dual_ff  <= crm_dual_ff;
            w_ff     <= crm_dual_ff ? W2 : W4;
            len_ff   <= crm_dual_ff ? ADDR_DUAL : ADDR_QUAD;
          end else begin
            state_ff <= D_OPC;
            w_ff     <= QPI_MODE ? W4 : W1;
            len_ff   <= QPI_MODE ? OPC_QPI_CLKS : OPC_SPI_CLKS;
          end
        end
        D_OPC: if (ph_end) begin
          if (op == OP_DIO && !QPI_MODE) begin
            state_ff <= D_ADDR;
            dual_ff  <= 1'b1;
            w_ff     <= W2;
            len_ff   <= ADDR_DUAL;
          end else if (op == OP_QIO && QUAD_ENABLE_BIT) begin
            state_ff <= D_ADDR;
            dual_ff  <= 1'b0;
            w_ff     <= W4;
            len_ff   <= ADDR_QUAD;
          end else if (op == OP_WRAP && QUAD_ENABLE_BIT && !QPI_MODE) begin
            state_ff <= D_WRAP;
            w_ff     <= W4;
            len_ff   <= WRAP_SET_CLKS;
          end else begin
            state_ff <= D_IGN;
          end
        end
        D_ADDR: if (ph_end) begin
          state_ff <= D_MODE;
          len_ff   <= dual_ff ? MODE_DUAL : MODE_QUAD;
        end
        D_MODE: if (ph_end) begin
          state_ff <= (dum_extra == 6'h00) ? D_DATA : D_DUM;
          len_ff   <= dum_extra;
        end
        D_DUM:  if (ph_end) state_ff <= D_DATA;
        D_WRAP: if (ph_end) state_ff <= D_IGN;
        D_DATA: state_ff <= D_DATA;
        D_IGN:  state_ff <= D_IGN;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read address and data output
  assign wmask   = (WRAP_MIN_LEN << wrap_ff[2:1]) - 24'h000001;
  assign wrap_on = !wrap_ff[0] && !dual_ff && !QPI_MODE;
  always_comb begin
    if (wrap_on) begin
      nxt_addr = (addr_ff & ~wmask)
               | ((addr_ff + 24'h000001) & wmask);
    end else begin
      nxt_addr = addr_ff + 24'h000001;
    end
  end
  assign cur      = (nib_ff == 3'h0) ? MEM_DATA : dsh_ff;
  assign last_nib = nib_ff == (dual_ff ? NIB_LAST_DUAL : NIB_LAST_QUAD);

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      addr_ff  <= 24'h000000;
      nib_ff   <= 3'h0;
      dsh_ff   <= 8'h00;
      dout_ff  <= 4'h0;
      doe_n_ff <= OE_OFF;
    end else if (state_ff != D_DATA || !cs_lo) begin
      nib_ff   <= 3'h0;
      doe_n_ff <= OE_OFF;
      if (state_ff == D_ADDR && ph_end) addr_ff <= nxt_sh;
    end else if (sclk_fall) begin
      // device drives only from the first data falling edge
      doe_n_ff <= dual_ff ? OE_DUAL : OE_QUAD;
      dout_ff  <= dual_ff ? {2'h0, cur[7:6]} : cur[7:4];
      dsh_ff   <= dual_ff ? {cur[5:0], 2'h0} : {cur[3:0], 4'h0};
      nib_ff   <= last_nib ? 3'h0 : nib_ff + 3'h1;
      if (last_nib) addr_ff <= nxt_addr;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // mode byte, wrap setting, read parameters, software reset
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      crm_ff      <= 1'b0;
      crm_dual_ff <= 1'b0;
      wrap_ff     <= WRAP_PWRUP;
      param_ff    <= PARAM_PWRUP;
      armed_ff    <= 1'b0;
      pend_ff     <= 1'b0;
      hold_ff     <= 12'h000;
      sw_rst_ff   <= 1'b0;
    end else begin
      if (state_ff == D_MODE && ph_end) begin
        crm_ff      <= nxt_sh[5:4] == SKIP_CODE;
        crm_dual_ff <= dual_ff;
      end
      if (sw_rst_ff) begin
        wrap_ff  <= WRAP_PWRUP;
        param_ff <= PARAM_PWRUP;
      end else begin
        if (state_ff == D_WRAP && ph_end) wrap_ff <= nxt_sh[6:4];
        if (PARAM_LD) param_ff <= PARAM_IN;
      end
      if (state_ff == D_OPC && ph_end) begin
        armed_ff <= op == OP_RSTEN && !POWERDOWN && !crm_ff;
        pend_ff  <= op == OP_RST && armed_ff && !POWERDOWN;
        hold_ff  <= 12'h000;
      end else if (cs_rise) begin
        pend_ff  <= 1'b0;
      end else if (pend_ff && hold_ff < RCH_CYC) begin
        hold_ff  <= hold_ff + 12'h001;
      end
      sw_rst_ff <= cs_rise && pend_ff && hold_ff >= RCH_CYC;
    end
  end

  assign MEM_ADDR            = addr_ff;
  assign WRAP_CONFIG_BITS    = wrap_ff;
  assign READ_PARAMETER_BITS = param_ff;
  assign CRM_ACTIVE          = crm_ff;
  assign RESET_ARMED         = armed_ff;
  assign SW_RESET            = sw_rst_ff;
  assign LNK.d_io_o          = dout_ff;
  assign LNK.d_io_oe_n       = doe_n_ff;
endmodule : sfr_dev
`default_nettype wire

// ### hdl/sfr_host.sv
// module: host flash controller end, makes the serial clock
`timescale 1ns/1ps
`default_nettype none
module sfr_host
  import sfr_pkg::*;
#(
  parameter int HALF = SCLK_HALF
)(
  input  wire logic        SYS_CLK,
  input  wire logic        RST,
  sfr_if.host              LNK,
  input  wire logic        CMD_VALID,
  input  wire sfr_kind_e   CMD_KIND,
  input  wire logic        CMD_QPI,
  input  wire logic        CMD_SKIP_OPC,
  input  wire logic [23:0] CMD_ADDR,
  input  wire logic [7:0]  CMD_MODE,
  input  wire logic [3:0]  CMD_DUMMY,
  input  wire logic [7:0]  CMD_LEN,
  output logic             CMD_READY,
  output logic      [7:0]  RD_DATA,
  output logic             RD_VALID
);
  sfr_hstate_e st_ff;
  sfr_kind_e   kind_ff;
  logic [11:0] cnt_ff;
  logic [11:0] rc_ff;
  logic        sclk_ff;
  logic        cs_n_ff;
  logic        step_ff;
  logic [39:0] tx_ff;
  logic [3:0]  io_o_ff;
  logic [3:0]  oe_n_ff;
  logic [2:0]  wo_ff;
  logic [2:0]  wa_ff;
  logic [11:0] n_opc_ff;
  logic [11:0] n_am_ff;
  logic [11:0] n_dum_ff;
  logic [11:0] n_dat_ff;
  logic [7:0]  rx_ff;
  logic [2:0]  nib_ff;
  logic [7:0]  rd_ff;
  logic        rdv_ff;
  logic [11:0] e1, e2, e3, tot;
  logic [11:0] gap_lim;
  logic        tick;
  logic        start;
  logic        again;
  logic        rise_ev;
  logic        fall_ev;
  logic        drive_ev;
  logic [2:0]  dw;
  logic [7:0]  opc;

  assign e1      = n_opc_ff;
  assign e2      = e1 + n_am_ff;
  assign e3      = e2 + n_dum_ff;
  assign tot     = e3 + n_dat_ff;
  assign tick    = cnt_ff == 12'(HALF - 1);
  assign start   = st_ff == H_IDLE && CMD_VALID;
  assign gap_lim = (kind_ff == K_RESET && step_ff) ? RST_CYC : CS_GAP_CYC;
  assign again   = kind_ff == K_RESET && !step_ff;
  assign rise_ev = st_ff == H_RUN && tick && !sclk_ff;
  assign fall_ev = st_ff == H_RUN && tick && sclk_ff;
  assign drive_ev = (st_ff == H_SETUP && tick) || (fall_ev && rc_ff != tot);
  assign dw      = (rc_ff < e1) ? wo_ff : wa_ff;

  //////////////////////////////////////////////////////////////////////
  // frame sequencer and serial clock divider
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_ff   <= H_IDLE;
      cnt_ff  <= 12'h000;
      rc_ff   <= 12'h000;
      sclk_ff <= 1'b0;
      cs_n_ff <= 1'b1;
      step_ff <= 1'b0;
    end else begin
      unique case (st_ff)
        H_IDLE: if (CMD_VALID) begin
          st_ff   <= H_SETUP;
          cs_n_ff <= 1'b0;
          cnt_ff  <= 12'h000;
          rc_ff   <= 12'h000;
          step_ff <= 1'b0;
        end
        H_SETUP: begin
          cnt_ff <= tick ? 12'h000 : cnt_ff + 12'h001;
          if (tick) st_ff <= H_RUN;
        end
        H_RUN: if (tick) begin
          cnt_ff  <= 12'h000;
          sclk_ff <= ~sclk_ff;
          if (!sclk_ff) rc_ff <= rc_ff + 12'h001;
          else if (rc_ff == tot) st_ff <= H_HOLD;
        end else begin
          cnt_ff <= cnt_ff + 12'h001;
        end
        H_HOLD: if (cnt_ff >= RCH_CYC - 12'h001) begin
          st_ff   <= H_GAP;
          cs_n_ff <= 1'b1;
          cnt_ff  <= 12'h000;
        end else begin
          cnt_ff <= cnt_ff + 12'h001;
        end
        H_GAP: if (cnt_ff >= gap_lim - 12'h001) begin
          cnt_ff <= 12'h000;
          if (again) begin
            st_ff   <= H_SETUP;
            cs_n_ff <= 1'b0;
            rc_ff   <= 12'h000;
            step_ff <= 1'b1;
          end else begin
            st_ff <= H_IDLE;
          end
        end else begin
          cnt_ff <= cnt_ff + 12'h001;
        end
        default: st_ff <= H_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // frame shape captured at command start
  always_comb begin
    unique case (CMD_KIND)
      K_DUAL:  opc = OP_DIO;
      K_QUAD:  opc = OP_QIO;
      K_WRAP:  opc = OP_WRAP;
      K_RESET: opc = OP_RSTEN;
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      kind_ff  <= K_DUAL;
      wo_ff    <= W1;
      wa_ff    <= W4;
      n_opc_ff <= 12'h000;
      n_am_ff  <= 12'h000;
      n_dum_ff <= 12'h000;
      n_dat_ff <= 12'h000;
    end else if (start) begin
      kind_ff  <= CMD_KIND;
      wo_ff    <= CMD_QPI ? W4 : W1;
      wa_ff    <= (CMD_KIND == K_DUAL) ? W2 : W4;
      n_opc_ff <= (CMD_SKIP_OPC && CMD_KIND <= K_QUAD) ? 12'h000 :
                  12'(CMD_QPI ? OPC_QPI_CLKS : OPC_SPI_CLKS);
      n_dum_ff <= (CMD_KIND <= K_QUAD) ? 12'(CMD_DUMMY) : 12'h000;
      unique case (CMD_KIND)
        K_DUAL: begin
          n_am_ff  <= 12'(ADDR_DUAL + MODE_DUAL);
          n_dat_ff <= {2'h0, CMD_LEN, 2'h0};
        end
        K_QUAD: begin
          n_am_ff  <= 12'(ADDR_QUAD + MODE_QUAD);
          n_dat_ff <= {3'h0, CMD_LEN, 1'h0};
        end
        K_WRAP: begin
          n_am_ff  <= 12'(WRAP_SET_CLKS);
          n_dat_ff <= 12'h000;
        end
        K_RESET: begin
          n_am_ff  <= 12'h000;
          n_dat_ff <= 12'h000;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // output lanes, changed while the serial clock is low
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      tx_ff   <= 40'h0;
      io_o_ff <= 4'h0;
      oe_n_ff <= OE_OFF;
    end else if (start) begin
      if (CMD_SKIP_OPC && CMD_KIND <= K_QUAD) begin
        tx_ff <= {CMD_ADDR, CMD_MODE, 8'h00};
      end else if (CMD_KIND == K_WRAP) begin
        tx_ff <= {opc, 24'h000000, CMD_MODE};
      end else begin
        tx_ff <= {opc, CMD_ADDR, CMD_MODE};
      end
    end else if (st_ff == H_GAP && again) begin
      tx_ff <= {OP_RST, 32'h0};
    end else if (drive_ev && rc_ff < e2) begin
      unique case (dw)
        W1: begin
          io_o_ff <= {3'h0, tx_ff[39]};
          oe_n_ff <= OE_SINGLE;
          tx_ff   <= {tx_ff[38:0], 1'h0};
        end
        W2: begin
          io_o_ff <= {2'h0, tx_ff[39:38]};
          oe_n_ff <= OE_DUAL;
          tx_ff   <= {tx_ff[37:0], 2'h0};
        end
        default: begin
          io_o_ff <= tx_ff[39:36];
          oe_n_ff <= OE_QUAD;
          tx_ff   <= {tx_ff[35:0], 4'h0};
        end
      endcase
    end else if (drive_ev || st_ff != H_RUN) begin
      oe_n_ff <= OE_OFF;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // read data capture on rising serial clock
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      rx_ff  <= 8'h00;
      nib_ff <= 3'h0;
      rd_ff  <= 8'h00;
      rdv_ff <= 1'b0;
    end else begin
      rdv_ff <= 1'b0;
      if (start) begin
        nib_ff <= 3'h0;
      end else if (rise_ev && rc_ff >= e3 && rc_ff < tot) begin
        if (wa_ff == W2) begin
          rx_ff <= {rx_ff[5:0], LNK.io[1:0]};
          if (nib_ff == NIB_LAST_DUAL) begin
            rd_ff  <= {rx_ff[5:0], LNK.io[1:0]};
            rdv_ff <= 1'b1;
          end
          nib_ff <= (nib_ff == NIB_LAST_DUAL) ? 3'h0 : nib_ff + 3'h1;
        end else begin
          rx_ff <= {rx_ff[3:0], LNK.io};
          if (nib_ff == NIB_LAST_QUAD) begin
            rd_ff  <= {rx_ff[3:0], LNK.io};
            rdv_ff <= 1'b1;
          end
          nib_ff <= (nib_ff == NIB_LAST_QUAD) ? 3'h0 : nib_ff + 3'h1;
        end
      end
    end
  end

  assign CMD_READY     = st_ff == H_IDLE;
  assign RD_DATA       = rd_ff;
  assign RD_VALID      = rdv_ff;
  assign LNK.sclk      = sclk_ff;
  assign LNK.cs_n      = cs_n_ff;
  assign LNK.h_io_o    = io_o_ff;
  assign LNK.h_io_oe_n = oe_n_ff;
endmodule : sfr_host
`default_nettype wire

// ### verif/sfr_link_properties.sv
// checker: wire-level properties of the serial flash link
`timescale 1ns/1ps
`default_nettype none
module sfr_link_chk
  import sfr_pkg::*;
(
  input wire logic       SYS_CLK,
  input wire logic       RST,
  input wire logic       sclk,
  input wire logic       cs_n,
  input wire logic [3:0] h_io_o,
  input wire logic [3:0] h_io_oe_n,
  input wire logic [3:0] d_io_o,
  input wire logic [3:0] d_io_oe_n,
  input wire logic [3:0] io
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  AST_IDLE_CLK: assert property (cs_n |-> !sclk)
    else $error("clock moves outside frame");
  AST_CLK_HIGH: assert property ($rose(sclk) |-> sclk[*4] ##1 !sclk)
    else $error("clock high phase wrong");
  AST_CLK_LOW: assert property ($fell(sclk) |-> !sclk[*4])
    else $error("clock low phase short");
  AST_CS_GAP: assert property ($rose(cs_n) |-> cs_n[*8])
    else $error("select gap short");
  AST_CS_HOLD: assert property ($rose(cs_n) |-> !$past(sclk))
    else $error("select rose with clock high");
  AST_DEV_RELEASE: assert property (cs_n[*4] |-> d_io_oe_n == OE_OFF)
    else $error("device holds lanes");
  AST_NO_FIGHT: assert property ((~h_io_oe_n & ~d_io_oe_n) == 4'h0)
    else $error("both ends drive a lane");
  AST_DEV_FALL: assert property (!cs_n && $changed(d_io_o)
    && d_io_oe_n != OE_OFF |-> !sclk) else $error("device data moved high");
  AST_HOST_FALL: assert property (!cs_n && $changed(h_io_o)
    && h_io_oe_n != OE_OFF |-> !sclk) else $error("host data moved high");
  AST_DEV_WIRE: assert property (d_io_oe_n == OE_QUAD |-> io == d_io_o)
    else $error("device lanes not on wire");
  cover property ($fell(cs_n));
  cover property (d_io_oe_n == OE_DUAL);
  cover property (d_io_oe_n == OE_QUAD);
endmodule : sfr_link_chk
`default_nettype wire

// ### verif/testbench.sv
// testbench: host and device ends joined, command table
`timescale 1ns/1ps
`default_nettype none
module testbench
  import sfr_pkg::*;
;
  typedef struct {
    sfr_kind_e   kind;
    logic        qpi, skip, qe, pd;
    logic [23:0] addr;
    logic [7:0]  mode;
    logic [3:0]  dum;
    logic [7:0]  len, par, pexp;
    logic [2:0]  wrap;
    logic        crm;
  } sfr_row_s;
  logic SYS_CLK = 1'b0, RST = 1'b1;
  logic QUAD_ENABLE_BIT, QPI_MODE, POWERDOWN, PARAM_LD, CMD_VALID, CMD_QPI;
  logic CMD_SKIP_OPC, CMD_READY, RD_VALID, CRM_ACTIVE, RESET_ARMED, SW_RESET;
  logic [7:0]  PARAM_IN, MEM_DATA, CMD_MODE, CMD_LEN, RD_DATA;
  logic [7:0]  READ_PARAMETER_BITS;
  logic [23:0] CMD_ADDR, MEM_ADDR;
  logic [3:0]  CMD_DUMMY;
  logic [2:0]  WRAP_CONFIG_BITS;
  sfr_kind_e   CMD_KIND;
  int          n_errors = 0, n_tests = 0, cyc = 0, n_sw = 0, k;
  int          n_arm = 0;
  logic        arm_q = 1'b0;
  sfr_row_s    r;
  sfr_row_s    rows [19] = '{
    '{K_DUAL,0,0,1,0,24'h000123,8'h00,0,3,8'h00,8'h00,1,0},
    '{K_QUAD,0,0,1,0,24'h0000FE,8'hFF,4,4,8'h00,8'h00,1,0},
    '{K_WRAP,0,0,0,0,24'h000000,8'h20,0,0,8'h00,8'h00,1,0},
    '{K_WRAP,0,0,1,0,24'h000000,8'h20,0,0,8'h00,8'h00,2,0},
    '{K_QUAD,0,0,1,0,24'h00001E,8'h00,4,4,8'h00,8'h00,2,0},
    '{K_QUAD,1,0,1,0,24'h00001E,8'h00,4,4,8'h20,8'h20,2,0},
    '{K_QUAD,0,0,1,0,24'h000200,8'h20,4,2,8'h20,8'h20,2,1},
    '{K_QUAD,0,1,1,0,24'h000300,8'h20,4,2,8'h20,8'h20,2,1},
    '{K_RESET,0,0,1,0,24'h000000,8'h00,0,0,8'h20,8'h20,2,0},
    '{K_RESET,0,0,1,1,24'h000000,8'h00,0,0,8'h20,8'h20,2,0},
    '{K_RESET,0,0,1,0,24'h000000,8'h00,0,0,8'h20,8'h00,1,0},
    '{K_DUAL,0,0,1,0,24'h000040,8'h20,0,1,8'h00,8'h00,1,1},
    '{K_DUAL,0,1,1,0,24'h7FFFFF,8'h00,0,2,8'h00,8'h00,1,0},
    '{K_WRAP,0,0,1,0,24'h000000,8'h60,0,0,8'h00,8'h00,6,0},
    '{K_QUAD,0,0,1,0,24'h00003E,8'h00,4,3,8'h00,8'h00,6,0},
    '{K_WRAP,0,0,1,0,24'h000000,8'h00,0,0,8'h00,8'h00,0,0},
    '{K_QUAD,0,0,1,0,24'h00000D,8'h00,4,4,8'h30,8'h30,0,0},
    '{K_QUAD,1,0,1,0,24'h000050,8'h00,6,2,8'h30,8'h30,0,0},
    '{K_QUAD,1,0,1,0,24'h000060,8'h00,2,2,8'h00,8'h00,0,0}};
  sfr_if LNK ();
  sfr_dev sfr_dev_inst (.*);
  sfr_host sfr_host_inst (.*);
  sfr_link_chk sfr_link_chk_inst (.SYS_CLK, .RST, .sclk(LNK.sclk),
    .cs_n(LNK.cs_n), .h_io_o(LNK.h_io_o), .h_io_oe_n(LNK.h_io_oe_n),
    .d_io_o(LNK.d_io_o), .d_io_oe_n(LNK.d_io_oe_n), .io(LNK.io));
  // memory content is a fixed pattern of the low address byte
  assign MEM_DATA = MEM_ADDR[7:0] ^ 8'h5A;
  always #25 SYS_CLK = ~SYS_CLK;
  //////////////////////////////////////////////////////////////////////////
  task automatic test_done();
    if (n_errors == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  task automatic chk(input string nm, input logic [23:0] e, g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  function automatic logic [7:0] exp_b(sfr_row_s x, int i);
    logic [23:0] a, n;
    n = 24'h000008 << x.wrap[2:1];
    a = x.addr + 24'(i);
    if (x.kind == K_QUAD && !x.qpi && !x.wrap[0])
      a = (x.addr & ~(n - 1)) | (a & (n - 1));
    return a[7:0] ^ 8'h5A;
  endfunction : exp_b
  always @(posedge SYS_CLK) begin
    cyc <= cyc + 1;
    if (SW_RESET === 1'b1) n_sw <= n_sw + 1;
    arm_q <= RESET_ARMED;
    if (RESET_ARMED === 1'b1 && arm_q !== 1'b1) n_arm <= n_arm + 1;
    if (cyc == 20000) begin
      n_errors++;
      test_done();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    {PARAM_LD, CMD_VALID, CMD_QPI, CMD_SKIP_OPC, QPI_MODE, POWERDOWN} = '0;
    {QUAD_ENABLE_BIT, PARAM_IN, CMD_MODE, CMD_LEN, CMD_ADDR} = '0;
    CMD_DUMMY = 4'h0;
    CMD_KIND = K_DUAL;
    repeat (16) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(posedge SYS_CLK);
    foreach (rows[i]) begin
      r = rows[i];
      {QUAD_ENABLE_BIT, QPI_MODE, CMD_QPI} <= {r.qe, r.qpi, r.qpi};
      {POWERDOWN, PARAM_IN, PARAM_LD, CMD_VALID} <= {r.pd, r.par, 2'b11};
      {CMD_SKIP_OPC, CMD_ADDR, CMD_MODE} <= {r.skip, r.addr, r.mode};
      {CMD_DUMMY, CMD_LEN} <= {r.dum, r.len};
      CMD_KIND <= r.kind;
      @(posedge SYS_CLK);
      {PARAM_LD, CMD_VALID} <= 2'b00;
      k = 0;
      do begin
        @(negedge SYS_CLK);
        if (RD_VALID === 1'b1) begin
          chk("read byte", exp_b(r, k), RD_DATA);
          k++;
        end
      end while (CMD_READY !== 1'b1);
      @(posedge SYS_CLK);
      chk("byte count", r.len, k);
      chk("wrap bits", r.wrap, WRAP_CONFIG_BITS);
      chk("skip mode", r.crm, CRM_ACTIVE);
      chk("read params", r.pexp, READ_PARAMETER_BITS);
    end
    chk("reset count", 1, n_sw);
    chk("armed count", 1, n_arm);
    RST <= 1'b1;
    repeat (2) @(posedge SYS_CLK);
    RST <= 1'b0;
    @(negedge SYS_CLK);
    chk("wrap at reset", 3'h1, WRAP_CONFIG_BITS);
    chk("params at reset", 8'h00, READ_PARAMETER_BITS);
    chk("select idle", 1'b1, LNK.cs_n);
    test_done();
  end
endmodule : testbench
`default_nettype wire
